// *** hw/ais_in_scale.sv ***
`timescale 1ns/1ps
`default_nettype none

module ais_in_scale
    import ais_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [ADC_BITS-1:0]  sample,
    input  wire logic                 sampleValid,
    input  wire logic signed [31:0]   span,
    input  wire logic signed [31:0]   bias,
    output logic signed [31:0]        result
);

    logic signed [ADC_BITS+32:0] product;
    logic signed [31:0]          next_result;

    // Raw sample is an unsigned fraction of 16384
    always_comb begin
        product     = $signed({1'b0, sample}) * span;
        next_result = 32'(product >>> SPAN_SHIFT) + bias;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            result <= RESULT_RST;
        end else if (sampleValid) begin
            result <= next_result;
        end
    end

    ///////////////////////////////////////////////////////////////////////

    a_zero_gives_bias: assert property (
        @(posedge clk) disable iff (!rst_n)
        (sampleValid && sample == '0) |=> result == $past(bias))
        else $error("zero sample did not yield the bias");

    a_result_holds: assert property (
        @(posedge clk) disable iff (!rst_n)
        !sampleValid |=> $stable(result))
        else $error("input result changed without a sample");

endmodule

`default_nettype wire

// *** hw/ais_pkg.sv ***
package ais_pkg;

    // Datapath widths
    localparam int ADC_BITS   = 14;
    localparam int DAC_BITS   = 12;
    localparam int CODE_BITS  = 16;
    localparam int WORD_BITS  = 32;
    localparam int ADDR_BITS  = 5;
    localparam int SHIFT_BITS = 6;
    localparam int CHANNELS   = 2;

    // Input divide by 16384 is an arithmetic shift by this amount
    localparam int SPAN_SHIFT = 14;

    // Register indices
    localparam logic [4:0] OFF_IN1_RESULT = 5'h00;
    localparam logic [4:0] OFF_IN2_RESULT = 5'h01;
    localparam logic [4:0] OFF_IN1_SPAN   = 5'h02;
    localparam logic [4:0] OFF_IN2_SPAN   = 5'h03;
    localparam logic [4:0] OFF_IN1_BIAS   = 5'h04;
    localparam logic [4:0] OFF_IN2_BIAS   = 5'h05;
    localparam logic [4:0] OFF_OUT1_VALUE = 5'h06;
    localparam logic [4:0] OFF_OUT2_VALUE = 5'h07;
    localparam logic [4:0] OFF_OUT1_SHIFT = 5'h08;
    localparam logic [4:0] OFF_OUT2_SHIFT = 5'h09;
    localparam logic [4:0] OFF_OUT1_BIAS  = 5'h0A;
    localparam logic [4:0] OFF_OUT2_BIAS  = 5'h0B;
    localparam logic [4:0] OFF_OUT1_POL   = 5'h0C;
    localparam logic [4:0] OFF_OUT2_POL   = 5'h0D;
    localparam logic [4:0] OFF_LINK_PER   = 5'h0E;
    localparam logic [4:0] OFF_LINK_CTL   = 5'h0F;

    // Link control field positions
    localparam int CTL_IN1_LINK  = 0;
    localparam int CTL_IN2_LINK  = 1;
    localparam int CTL_OUT1_LINK = 2;
    localparam int CTL_OUT2_LINK = 3;
    localparam int CTL_BITS      = 4;

    // Reset values
    localparam logic [31:0] SPAN_RST   = 32'h00004000;
    localparam logic [31:0] BIAS_RST   = 32'h00000000;
    localparam logic [31:0] VALUE_RST  = 32'h00000000;
    localparam logic [31:0] RESULT_RST = 32'h00000000;
    localparam logic [31:0] PERIOD_RST = 32'h00000000;
    localparam logic [5:0]  SHIFT_RST  = 6'h00;
    localparam logic [3:0]  CTL_RST    = 4'h0;
    localparam logic        INVERT_RST = 1'b0;

    // Polarity read-back words
    localparam logic [31:0] POL_PASS_WORD   = 32'h00000001;
    localparam logic [31:0] POL_INVERT_WORD = 32'hFFFFFFFF;

    // Timing: link period is counted in units of one millisecond
    localparam int CLK_PERIOD_NS    = 50;
    localparam int LINK_UNIT_NS     = 1000000;
    localparam int LINK_UNIT_CYCLES = LINK_UNIT_NS / CLK_PERIOD_NS;

endpackage

// *** hw/analog_io_scaling.sv ***
//
// Function
// - Two 14-bit input channels and two 12-bit output channels exist.
// - Input result is raw sample over 16384 times span plus bias.
// - Input result, span and bias are signed 32-bit values.
// - Input two uses its own span and bias with the same formula.
// - Output raw code is signed 16-bit with 12 effective bits.
// - Output code is value times two to the shift factor plus bias.
// - Output code wraps modulo 2^16 and never saturates.
// - Each output has its own polarity setting for its sign.
// - Input results are readable any time or copied out each link period.
// - Output values are written directly or refreshed each link period.
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module analog_io_scaling
    import ais_pkg::*;
#(
    parameter int TICK_CYCLES = LINK_UNIT_CYCLES
)
(
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    input  wire logic [ADDR_BITS-1:0]  regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWr,
    input  wire logic                  regRd,
    output logic [31:0]                regRdata,
    input  wire logic [ADC_BITS-1:0]   adcOneSample,
    input  wire logic                  adcOneValid,
    input  wire logic [ADC_BITS-1:0]   adcTwoSample,
    input  wire logic                  adcTwoValid,
    output logic [CODE_BITS-1:0]       dacOneCode,
    output logic [DAC_BITS-1:0]        dacOneLevel,
    output logic [CODE_BITS-1:0]       dacTwoCode,
    output logic [DAC_BITS-1:0]        dacTwoLevel,
    input  wire logic [31:0]           srcOneValue,
    input  wire logic [31:0]           srcTwoValue,
    output logic                       destOneWr,
    output logic [31:0]                destOneData,
    output logic                       destTwoWr,
    output logic [31:0]                destTwoData,
    output logic                       linkTick
);

    ///////////////////////////////////////////////////////////////////////

    logic signed [31:0]            inSpan     [CHANNELS];
    logic signed [31:0]            inBias     [CHANNELS];
    logic signed [31:0]            inResult   [CHANNELS];
    logic signed [31:0]            outValue   [CHANNELS];
    logic signed [SHIFT_BITS-1:0]  outShift   [CHANNELS];
    logic signed [31:0]            outBias    [CHANNELS];
    logic                          outInvert  [CHANNELS];
    logic [CODE_BITS-1:0]          dacCode    [CHANNELS];
    logic [ADC_BITS-1:0]           adcSample  [CHANNELS];
    logic                          adcValid   [CHANNELS];
    logic [31:0]                   srcValue   [CHANNELS];
    logic [31:0]                   linkPeriod;
    logic [CTL_BITS-1:0]           linkCtl;
    logic [31:0]                   unitCnt;
    logic [31:0]                   periodCnt;
    logic                          unitTick;

    assign adcSample[0] = adcOneSample;
    assign adcSample[1] = adcTwoSample;
    assign adcValid[0]  = adcOneValid;
    assign adcValid[1]  = adcTwoValid;
    assign srcValue[0]  = srcOneValue;
    assign srcValue[1]  = srcTwoValue;

    // Channel of a per-channel register pair, low bit of the index
    function automatic int unsigned chanOf(input logic [ADDR_BITS-1:0] a);
        return {31'h0, a[0]};
    endfunction

    // Shift, add bias, wrap to 16 bits, then apply polarity
    function automatic logic [CODE_BITS-1:0] outCode(
        input logic signed [31:0]           val,
        input logic signed [SHIFT_BITS-1:0] sf,
        input logic signed [31:0]           bias,
        input logic                         inv
    );
        logic signed [31:0]    scaled;
        logic [SHIFT_BITS-1:0] amt;
        logic [CODE_BITS-1:0]  raw;
        amt    = (sf < 0) ? SHIFT_BITS'(-sf) : SHIFT_BITS'(sf);
        scaled = (sf < 0) ? (val >>> amt) : (val <<< amt);
        raw    = CODE_BITS'(scaled + bias);
        return inv ? CODE_BITS'(-raw) : raw;
    endfunction

    ///////////////////////////////////////////////////////////////////////
    // Input settings

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                inSpan[i] <= SPAN_RST;
                inBias[i] <= BIAS_RST;
            end
        end else if (regWr) begin
            case (regAddr)
                OFF_IN1_SPAN, OFF_IN2_SPAN: begin
                    inSpan[chanOf(regAddr)] <= regWdata;
                end
                OFF_IN1_BIAS, OFF_IN2_BIAS: begin
                    inBias[chanOf(regAddr)] <= regWdata;
                end
                default: begin
                end
            endcase
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Input scaling, one per channel

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_in
            ais_in_scale u_scale (
                .clk         (clk),
                .rst_n       (rst_n),
                .sample      (adcSample[ch]),
                .sampleValid (adcValid[ch]),
                .span        (inSpan[ch]),
                .bias        (inBias[ch]),
                .result      (inResult[ch])
            );
        end
    endgenerate

    ///////////////////////////////////////////////////////////////////////
    // Output settings

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            for (int i = 0; i < CHANNELS; i++) begin
                outShift[i]  <= SHIFT_RST;
                outBias[i]   <= BIAS_RST;
                outInvert[i] <= INVERT_RST;
            end
        end else if (regWr) begin
            case (regAddr)
                OFF_OUT1_SHIFT: outShift[0] <= regWdata[SHIFT_BITS-1:0];
                OFF_OUT2_SHIFT: outShift[1] <= regWdata[SHIFT_BITS-1:0];
                OFF_OUT1_BIAS:  outBias[0]  <= regWdata;
                OFF_OUT2_BIAS:  outBias[1]  <= regWdata;
                OFF_OUT1_POL:   outInvert[0] <= regWdata[31];
                OFF_OUT2_POL:   outInvert[1] <= regWdata[31];
                default: begin
                end
            endcase
        end
    end

    // Output values: software write wins over a link refresh
    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_outval
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    outValue[ch] <= VALUE_RST;
                end else if (regWr &&
                             regAddr == OFF_OUT1_VALUE + 5'(ch)) begin
                    outValue[ch] <= regWdata;
                end else if (linkTick && linkCtl[CTL_OUT1_LINK + ch]) begin
                    outValue[ch] <= srcValue[ch];
                end
            end
        end
    endgenerate

    ///////////////////////////////////////////////////////////////////////
    // Output codes

    generate
        for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_code
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    dacCode[ch] <= '0;
                end else begin
                    dacCode[ch] <= outCode(outValue[ch], outShift[ch],
                                           outBias[ch], outInvert[ch]);
                end
            end
        end
    endgenerate

    // Converter uses the upper 12 bits of the 16-bit code
    assign dacOneCode  = dacCode[0];
    assign dacTwoCode  = dacCode[1];
    assign dacOneLevel = dacCode[0][CODE_BITS-1 -: DAC_BITS];
    assign dacTwoLevel = dacCode[1][CODE_BITS-1 -: DAC_BITS];

    ///////////////////////////////////////////////////////////////////////
    // Link timer

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            linkPeriod <= PERIOD_RST;
            linkCtl    <= CTL_RST;
        end else if (regWr && regAddr == OFF_LINK_PER) begin
            linkPeriod <= regWdata;
        end else if (regWr && regAddr == OFF_LINK_CTL) begin
            linkCtl <= regWdata[CTL_BITS-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            unitCnt  <= '0;
            unitTick <= 1'b0;
        end else if (unitCnt == 32'(TICK_CYCLES - 1)) begin
            unitCnt  <= '0;
            unitTick <= 1'b1;
        end else begin
            unitCnt  <= unitCnt + 32'h00000001;
            unitTick <= 1'b0;
        end
    end

    // A zero period stops the cyclic copies
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            periodCnt <= '0;
            linkTick  <= 1'b0;
        end else if (linkPeriod == '0) begin
            periodCnt <= '0;
            linkTick  <= 1'b0;
        end else if (unitTick) begin
            if (periodCnt >= linkPeriod - 32'h00000001) begin
                periodCnt <= '0;
                linkTick  <= 1'b1;
            end else begin
                periodCnt <= periodCnt + 32'h00000001;
                linkTick  <= 1'b0;
            end
        end else begin
            linkTick <= 1'b0;
        end
    end

    // Cyclic copy of the input results to their destinations
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            destOneWr   <= 1'b0;
            destTwoWr   <= 1'b0;
            destOneData <= '0;
            destTwoData <= '0;
        end else begin
            destOneWr <= linkTick && linkCtl[CTL_IN1_LINK];
            destTwoWr <= linkTick && linkCtl[CTL_IN2_LINK];
            if (linkTick) begin
                destOneData <= inResult[0];
                destTwoData <= inResult[1];
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Register read

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            regRdata <= '0;
        end else if (regRd) begin
            case (regAddr)
                OFF_IN1_RESULT, OFF_IN2_RESULT:
                    regRdata <= inResult[chanOf(regAddr)];
                OFF_IN1_SPAN, OFF_IN2_SPAN:
                    regRdata <= inSpan[chanOf(regAddr)];
                OFF_IN1_BIAS, OFF_IN2_BIAS:
                    regRdata <= inBias[chanOf(regAddr)];
                OFF_OUT1_VALUE: regRdata <= outValue[0];
                OFF_OUT2_VALUE: regRdata <= outValue[1];
                OFF_OUT1_SHIFT: regRdata <= 32'(outShift[0]);
                OFF_OUT2_SHIFT: regRdata <= 32'(outShift[1]);
                OFF_OUT1_BIAS:  regRdata <= outBias[0];
                OFF_OUT2_BIAS:  regRdata <= outBias[1];
                OFF_OUT1_POL:
                    regRdata <= outInvert[0] ? POL_INVERT_WORD
                                             : POL_PASS_WORD;
                OFF_OUT2_POL:
                    regRdata <= outInvert[1] ? POL_INVERT_WORD
                                             : POL_PASS_WORD;
                OFF_LINK_PER:   regRdata <= linkPeriod;
                OFF_LINK_CTL:   regRdata <= {28'h0, linkCtl};
                default:        regRdata <= '0;
            endcase
        end else begin
            regRdata <= '0;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_link_fire(int bit_pos);
        linkTick && linkCtl[bit_pos];
    endsequence

    sequence s_no_sw_out1;
        !(regWr && regAddr == OFF_OUT1_VALUE);
    endsequence

    a_dest_one_copy: assert property (
        @(posedge clk) disable iff (!rst_n)
        s_link_fire(CTL_IN1_LINK) |=>
            destOneWr && destOneData == $past(inResult[0]))
        else $error("input one result not copied on link tick");

    a_out_link_refresh: assert property (
        @(posedge clk) disable iff (!rst_n)
        (s_link_fire(CTL_OUT1_LINK) and s_no_sw_out1) |=>
            outValue[0] == $past(srcOneValue))
        else $error("output one not refreshed on link tick");

    a_no_tick_idle: assert property (
        @(posedge clk) disable iff (!rst_n)
        (linkPeriod == '0) |=> !linkTick)
        else $error("link tick with zero period");

    a_code_passthru: assert property (
        @(posedge clk) disable iff (!rst_n)
        (outShift[0] == '0 && outBias[0] == '0 && !outInvert[0]) |=>
            dacOneCode == $past(outValue[0][15:0]))
        else $error("plain output code differs from value");

    a_code_shift_left: assert property (
        @(posedge clk) disable iff (!rst_n)
        (outShift[1] == 6'h01 && outBias[1] == '0 && !outInvert[1]) |=>
            dacTwoCode == {$past(outValue[1][14:0]), 1'b0})
        else $error("shift by one not doubling the code");

    a_code_wraps: assert property (
        @(posedge clk) disable iff (!rst_n)
        (outShift[0] == '0 && outBias[0] == 32'h00000001 &&
         !outInvert[0] && outValue[0] == 32'h00007FFF) |=>
            dacOneCode == 16'h8000)
        else $error("output code saturated instead of wrapping");

    a_pol_invert: assert property (
        @(posedge clk) disable iff (!rst_n)
        (outShift[1] == '0 && outBias[1] == '0 && outInvert[1]) |=>
            dacTwoCode == 16'(-$past(outValue[1][15:0])))
        else $error("inverted polarity not negating the code");

    a_rd_unmapped: assert property (
        @(posedge clk) disable iff (!rst_n)
        (regRd && regAddr > OFF_LINK_CTL) |=> regRdata == '0)
        else $error("unmapped read returned nonzero data");

endmodule

`default_nettype wire

// *** sim/ais_conv_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module ais_conv_model
    import ais_pkg::*;
(
    input  wire logic                clk,
    output logic [ADC_BITS-1:0]      adcOneSample,
    output logic                     adcOneValid,
    output logic [ADC_BITS-1:0]      adcTwoSample,
    output logic                     adcTwoValid
);
    initial begin
        adcOneSample <= '0;
        adcOneValid  <= 1'b0;
        adcTwoSample <= '0;
        adcTwoValid  <= 1'b0;
    end

    // One 14-bit conversion per call, held for the taking edge only
    task automatic convert(input int ch, input logic [ADC_BITS-1:0] s);
        @(posedge clk);
        if (ch == 0) begin
            adcOneSample <= s;
            adcOneValid  <= 1'b1;
        end else begin
            adcTwoSample <= s;
            adcTwoValid  <= 1'b1;
        end
        @(posedge clk);
        // Stale sample must not look valid after the strobe drops
        adcOneValid  <= 1'b0;
        adcTwoValid  <= 1'b0;
        adcOneSample <= ~adcOneSample;
        adcTwoSample <= ~adcTwoSample;
    endtask
endmodule

`default_nettype wire

// *** sim/analog_io_scaling_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module analog_io_scaling_tb_top
    import ais_pkg::*;
;
    localparam int TICKS = 4;

    logic                 clk;
    logic                 rst_n;
    logic [ADDR_BITS-1:0] regAddr;
    logic [31:0]          regWdata;
    logic                 regWr;
    logic                 regRd;
    logic [31:0]          regRdata;
    logic [ADC_BITS-1:0]  adcOneSample;
    logic                 adcOneValid;
    logic [ADC_BITS-1:0]  adcTwoSample;
    logic                 adcTwoValid;
    logic [CODE_BITS-1:0] dacOneCode;
    logic [DAC_BITS-1:0]  dacOneLevel;
    logic [CODE_BITS-1:0] dacTwoCode;
    logic [DAC_BITS-1:0]  dacTwoLevel;
    logic [31:0]          srcOneValue;
    logic [31:0]          srcTwoValue;
    logic                 destOneWr;
    logic [31:0]          destOneData;
    logic                 destTwoWr;
    logic [31:0]          destTwoData;
    logic                 linkTick;
    int                   nFail;
    int                   testsRun;
    int                   cycles;

    analog_io_scaling #(.TICK_CYCLES(TICKS)) analog_io_scaling_inst (
        .clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .adcOneSample(adcOneSample), .adcOneValid(adcOneValid),
        .adcTwoSample(adcTwoSample), .adcTwoValid(adcTwoValid),
        .dacOneCode(dacOneCode), .dacOneLevel(dacOneLevel),
        .dacTwoCode(dacTwoCode), .dacTwoLevel(dacTwoLevel),
        .srcOneValue(srcOneValue), .srcTwoValue(srcTwoValue),
        .destOneWr(destOneWr), .destOneData(destOneData),
        .destTwoWr(destTwoWr), .destTwoData(destTwoData),
        .linkTick(linkTick)
    );

    ais_conv_model ais_conv_model_inst (
        .clk(clk), .adcOneSample(adcOneSample), .adcOneValid(adcOneValid),
        .adcTwoSample(adcTwoSample), .adcTwoValid(adcTwoValid)
    );

    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            nFail++;
            finishTest();
        end
    end

    task automatic finishTest();
        $display("Comparisons %0d, mismatches %0d", testsRun, nFail);
        if (nFail == 0 && testsRun > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
        testsRun++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chkFlag(input logic got, input logic exp);
        chkWord({31'h0, got}, {31'h0, exp});
    endtask

    task automatic regWrite(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic regCheck(input logic [4:0] a, input logic [31:0] e);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        chkWord(regRdata, e);
    endtask

    task automatic waitTick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (linkTick !== 1'b1 && n < 200);
    endtask

    function automatic logic [31:0] inExp(input logic [13:0] s,
                                          input longint span,
                                          input longint bias);
        return 32'(((longint'(s) * span) >>> SPAN_SHIFT) + bias);
    endfunction

    function automatic logic [15:0] outExp(input longint v, input int sf,
                                           input longint b, input bit inv);
        logic [15:0] c;
        c = 16'(((sf >= 0) ? (v <<< sf) : (v >>> -sf)) + b);
        return inv ? 16'(-c) : c;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] rstVal [16] = '{RESULT_RST, RESULT_RST, SPAN_RST, SPAN_RST,
        BIAS_RST, BIAS_RST, VALUE_RST, VALUE_RST, 32'h00000000, 32'h00000000,
        BIAS_RST, BIAS_RST, POL_PASS_WORD, POL_PASS_WORD, PERIOD_RST,
        32'h00000000};
    logic [13:0] smp [3] = '{14'h0000, 14'h3FFF, 14'h2000};
    int          vals [5] = '{1000, 8191, 32767, -5, 131068};
    int          sfs [5] = '{-2, 2, 0, 3, -2};
    int          bis [5] = '{0, 0, 1, 100, 0};
    bit          invs [5] = '{0, 1, 0, 0, 1};
    logic [31:0] lastOne;
    logic [31:0] lastTwo;
    logic [15:0] e;
    logic [15:0] keepOne;
    logic [4:0]  o;
    int          n;

    initial begin
        rst_n <= 1'b0;
        regAddr <= '0;
        regWdata <= '0;
        regWr <= 1'b0;
        regRd <= 1'b0;
        srcOneValue <= 32'h00000000;
        srcTwoValue <= 32'h00000000;
        nFail = 0;
        testsRun = 0;
        cycles <= 0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 16; a++) regCheck(5'(a), rstVal[a]);
        regCheck(5'h10, 32'h00000000);
        regWrite(OFF_IN1_RESULT, 32'h12345678);
        regCheck(OFF_IN1_RESULT, 32'h00000000);
        // Input scaling on both channels with their own settings
        regWrite(OFF_IN1_SPAN, 32'h000186A0);
        regWrite(OFF_IN1_BIAS, 32'hFFFF3CB0);
        regWrite(OFF_IN2_SPAN, 32'hFFFFC180);
        regWrite(OFF_IN2_BIAS, 32'h00001F40);
        for (int i = 0; i < 3; i++) begin
            ais_conv_model_inst.convert(0, smp[i]);
            ais_conv_model_inst.convert(1, smp[i] ^ 14'h1555);
            lastOne = inExp(smp[i], 100000, -50000);
            lastTwo = inExp(smp[i] ^ 14'h1555, -16000, 8000);
            regCheck(OFF_IN1_RESULT, lastOne);
            regCheck(OFF_IN2_RESULT, lastTwo);
        end
        regWrite(OFF_IN1_SPAN, 32'h7FFFFFFF);
        ais_conv_model_inst.convert(0, 14'h3FFF);
        lastOne = inExp(14'h3FFF, 2147483647, -50000);
        regCheck(OFF_IN1_RESULT, lastOne);
        // Output codes: shift both ways, wrap, polarity, per channel
        for (int ch = 0; ch < 2; ch++) begin
            o = 5'(ch);
            for (int k = 0; k < 5; k++) begin
                regWrite(OFF_OUT1_VALUE + o, 32'(vals[k]));
                regWrite(OFF_OUT1_SHIFT + o, 32'(sfs[k]));
                regWrite(OFF_OUT1_BIAS + o, 32'(bis[k]));
                regWrite(OFF_OUT1_POL + o,
                         invs[k] ? POL_INVERT_WORD : POL_PASS_WORD);
                repeat (2) @(posedge clk);
                #1;
                e = outExp(vals[k], sfs[k], bis[k], invs[k]);
                if (ch == 0) begin
                    keepOne = e;
                    chkWord({16'h0000, dacOneCode}, {16'h0000, e});
                    chkWord({20'h00000, dacOneLevel}, {20'h00000, e[15:4]});
                end else begin
                    chkWord({16'h0000, dacTwoCode}, {16'h0000, e});
                    chkWord({20'h00000, dacTwoLevel}, {20'h00000, e[15:4]});
                end
                regCheck(OFF_OUT1_SHIFT + o, 32'(sfs[k]));
                regCheck(OFF_OUT1_POL + o,
                         invs[k] ? POL_INVERT_WORD : POL_PASS_WORD);
            end
        end
        chkWord({16'h0000, dacOneCode}, {16'h0000, keepOne});
        // Shift by one on output two doubles the value
        regWrite(OFF_OUT2_POL, POL_PASS_WORD);
        regWrite(OFF_OUT2_SHIFT, 32'h00000001);
        repeat (2) @(posedge clk);
        #1;
        e = outExp(vals[4], 1, 0, 1'b0);
        chkWord({16'h0000, dacTwoCode}, {16'h0000, e});
        // Cyclic link in both directions
        srcOneValue <= 32'hA5A50123;
        srcTwoValue <= 32'h0000ABCD;
        regWrite(OFF_LINK_CTL, 32'h0000000F);
        regWrite(OFF_LINK_PER, 32'h00000002);
        waitTick(n);
        @(posedge clk);
        #1;
        chkFlag(destOneWr, 1'b1);
        chkWord(destOneData, lastOne);
        chkFlag(destTwoWr, 1'b1);
        chkWord(destTwoData, lastTwo);
        waitTick(n);
        chkWord(32'(n), 32'(2 * TICKS - 1));
        regCheck(OFF_OUT1_VALUE, 32'hA5A50123);
        regCheck(OFF_OUT2_VALUE, 32'h0000ABCD);
        regWrite(OFF_LINK_CTL, 32'h00000000);
        srcOneValue <= 32'h00000055;
        waitTick(n);
        @(posedge clk);
        #1;
        chkFlag(destOneWr, 1'b0);
        regCheck(OFF_OUT1_VALUE, 32'hA5A50123);
        finishTest();
    end
endmodule

`default_nettype wire
